// [hdl/dma_channel_trigger_event_control.sv]
`timescale 1ns/1ps
`default_nettype none
module dma_channel_trigger_event_control
  import dma_trig_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral requests and event system (asynchronous)
  input wire logic [NUM_PERIPH_REQ-1:0] periph_req,
  input wire logic [NUM_EVENT_CHANNELS-1:0] event_in,
  // Output-event conditions from descriptor logic (same clock)
  input wire logic [NUM_CHANNELS-1:0] event_out_cond,
  // Toward the transfer engine and arbiter
  output logic [NUM_CHANNELS-1:0] channel_trigger,
  output logic [NUM_CHANNELS*2-1:0] trigger_granularity,
  output logic [NUM_CHANNELS-1:0] channel_suspended,
  output logic [NUM_CHANNELS*3-1:0] event_action_pulse,
  output logic [NUM_EVENT_CHANNELS-1:0] event_out,
  output logic [CHAN_W-1:0] top_priority_channel,
  output logic top_priority_valid,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [NUM_CHANNELS-1:0][31:0] ctrl;
    logic [NUM_CHANNELS-1:0] enable;
    logic [NUM_CHANNELS-1:0] suspend_flag;
    logic [NUM_CHANNELS-1:0] flag;
    logic [NUM_CHANNELS-1:0] mask;
    logic [CHAN_W-1:0] sel;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NUM_PERIPH_REQ-1:0] req_s1;
    logic [NUM_PERIPH_REQ-1:0] req_s2;
    logic [NUM_PERIPH_REQ-1:0] req_prev;
    logic [NUM_EVENT_CHANNELS-1:0] ev_s1;
    logic [NUM_EVENT_CHANNELS-1:0] ev_s2;
    logic [NUM_EVENT_CHANNELS-1:0] ev_prev;
    logic [NUM_CHANNELS-1:0] trig;
    logic [NUM_CHANNELS*3-1:0] act;
    logic [NUM_EVENT_CHANNELS-1:0] evo;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [NUM_PERIPH_REQ-1:0] req_rise;
  logic [NUM_EVENT_CHANNELS-1:0] ev_rise;
  logic [NUM_CHANNELS-1:0] chan_valid_src;
  logic [NUM_CHANNELS-1:0] suspend_flag_set;
  logic [NUM_CHANNELS-1:0] resume_set;

  assign req_rise = state_reg.req_s2 & ~state_reg.req_prev;
  assign ev_rise = state_reg.ev_s2 & ~state_reg.ev_prev;

  // Legal trigger source per channel; reserved codes never trigger
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_src
      logic [5:0] src;
      assign src = state_reg.ctrl[gi][TRIG_SRC_LSB +: 6];
      assign chan_valid_src[gi] = (src != SRC_NONE) &&
        ((src <= SRC_DAC1_EMPTY) || (src == SRC_CIPHER_WR) ||
         (src == SRC_CIPHER_RD)) && (src < 6'(NUM_PERIPH_REQ));
    end
  endgenerate

  // Register read mux
  function automatic logic [31:0] read_word(input state_t s, input logic [7:0] addr,
                                            output logic bad);
    logic [31:0] val;
    val = 32'h0000_0000;
    bad = 1'b0;
    unique case (addr)
      CHANNEL_SELECT_OFFSET: val[CHAN_W-1:0] = s.sel;
      CHANNEL_ENABLE_OFFSET: val[0] = s.enable[s.sel];
      CONTROL_OFFSET: begin
        val = s.ctrl[s.sel];
        val[CMD_LSB +: 2] = CMD_NONE; // Command reads back as idle
      end
      SUSPEND_STATUS_OFFSET: val[NUM_CHANNELS-1:0] = s.suspend_flag;
      IRQ_STATUS_OFFSET: val[NUM_CHANNELS-1:0] = s.flag;
      IRQ_MASK_OFFSET: val[NUM_CHANNELS-1:0] = s.mask;
      default: bad = 1'b1;
    endcase
    return val;
  endfunction

  // Next-state logic: bus slave, per-channel control, triggers, events
  always_comb begin
    logic wr_go;
    logic rd_bad;
    logic [31:0] wd;
    logic [31:0] old;
    logic [31:0] merged;
    logic [31:0] keep;
    logic [1:0] cmd;
    logic [2:0] ea;
    logic [5:0] src;
    logic [1:0] gran;
    wr_go = 1'b0;
    rd_bad = 1'b0;
    wd = 32'h0000_0000;
    old = 32'h0000_0000;
    merged = 32'h0000_0000;
    keep = 32'h0000_0000;
    cmd = CMD_NONE;
    ea = EVENT_INPUT_ACTION_NONE;
    src = SRC_NONE;
    gran = GRAN_BLOCK;
    suspend_flag_set = '0;
    resume_set = '0;
    state_next = state_reg;

    // Two-flop synchronisers, then edge history on the second stage
    state_next.req_s1 = periph_req;
    state_next.req_s2 = state_reg.req_s1;
    state_next.req_prev = state_reg.req_s2;
    state_next.ev_s1 = event_in;
    state_next.ev_s2 = state_reg.ev_s1;
    state_next.ev_prev = state_reg.ev_s2;

    // Write channel: capture address and data in either order
    if (s_axi_awvalid && !state_reg.aw_held) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_held) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    wr_go = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Per-channel triggers and event actions, default idle
    state_next.trig = '0;
    state_next.act = '0;
    state_next.evo = '0;
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      src = state_reg.ctrl[c][TRIG_SRC_LSB +: 6];
      gran = state_reg.ctrl[c][TRIG_GRAN_LSB +: 2];
      // Reserved granularity starts nothing
      if (state_reg.enable[c] && !state_reg.suspend_flag[c] && chan_valid_src[c] &&
          gran != GRAN_RSVD && req_rise[src]) begin
        state_next.trig[c] = 1'b1;
      end
      if (c < NUM_EVENT_CHANNELS) begin
        ea = state_reg.ctrl[c][EVENT_INPUT_ACTION_LSB +: 3];
        if (state_reg.ctrl[c][EVENT_INPUT_ENABLE_BIT] && ev_rise[c]) begin
          unique case (ea)
            EVENT_INPUT_ACTION_SUSPEND: suspend_flag_set[c] = 1'b1;
            EVENT_INPUT_ACTION_RESUME: resume_set[c] = 1'b1;
            EVENT_INPUT_ACTION_TRANSFER, EVENT_INPUT_ACTION_COND_TRIGGER, EVENT_INPUT_ACTION_COND_BLOCK, EVENT_INPUT_ACTION_SKIP_SUSPEND:
              state_next.act[c*3 +: 3] = ea;
            default: state_next.act[c*3 +: 3] = EVENT_INPUT_ACTION_NONE;
          endcase
        end
        state_next.evo[c] = state_reg.ctrl[c][EVENT_OUTPUT_ENABLE_BIT] && event_out_cond[c];
      end
    end

    // Register write, after the write address and data are both held
    if (wr_go) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        keep[b*8 +: 8] = {8{state_reg.w_strb[b]}};
      end
      wd = state_reg.w_data;
      unique case (state_reg.aw_addr)
        CHANNEL_SELECT_OFFSET: begin
          if (state_reg.w_strb[0]) begin
            state_next.sel = wd[CHAN_W-1:0];
          end
        end
        CHANNEL_ENABLE_OFFSET: begin
          if (state_reg.w_strb[0]) begin
            state_next.enable[state_reg.sel] = wd[0];
          end
        end
        CONTROL_OFFSET: begin
          old = state_reg.ctrl[state_reg.sel];
          merged = (wd & keep) | (old & ~keep);
          // While enabled only command and priority move; the rest is locked
          if (state_reg.enable[state_reg.sel]) begin
            merged = old;
            if (state_reg.w_strb[0]) begin
              merged[PRIO_LSB +: 2] = wd[PRIO_LSB +: 2];
            end
            if (state_reg.w_strb[3]) begin
              merged[CMD_LSB +: 2] = wd[CMD_LSB +: 2];
            end
          end
          cmd = merged[CMD_LSB +: 2];
          merged[CMD_LSB +: 2] = CMD_NONE; // Command is an action, not stored
          if (state_reg.sel >= CHAN_W'(NUM_EVENT_CHANNELS)) begin
            merged[EVENT_INPUT_ACTION_LSB +: 5] = 5'h00;
          end
          // Unused bit positions stay zero
          merged[31:26] = 6'h00;
          merged[21:14] = 8'h00;
          merged[7] = 1'b0;
          state_next.ctrl[state_reg.sel] = merged;
          if (state_reg.w_strb[3]) begin
            unique case (cmd)
              CMD_SUSPEND: suspend_flag_set[state_reg.sel] = 1'b1;
              CMD_RESUME: resume_set[state_reg.sel] = 1'b1;
              default: ;
            endcase
          end
        end
        IRQ_STATUS_OFFSET: begin
          if (state_reg.w_strb[0]) begin
            state_next.flag = state_reg.flag & ~wd[NUM_CHANNELS-1:0];
          end
        end
        IRQ_MASK_OFFSET: begin
          if (state_reg.w_strb[0]) begin
            state_next.mask = wd[NUM_CHANNELS-1:0];
          end
        end
        SUSPEND_STATUS_OFFSET: ;
        default: state_next.bresp = RESP_SLVERR;
      endcase
    end

    // Suspend state and sticky flag; a set beats a same-cycle clear
    state_next.suspend_flag = (state_next.suspend_flag & ~resume_set) | suspend_flag_set;
    state_next.flag = state_next.flag | suspend_flag_set;

    // Read channel: one outstanding read
    if (s_axi_arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = read_word(state_reg, s_axi_araddr, rd_bad);
      state_next.rresp = rd_bad ? RESP_SLVERR : RESP_OKAY;
      if (rd_bad) begin
        state_next.rdata = 32'h0000_0000;
      end
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  // Single state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Highest enabled level wins, lowest channel breaks ties
  always_comb begin
    logic [1:0] best;
    best = 2'h0;
    top_priority_valid = 1'b0;
    top_priority_channel = '0;
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      if (state_reg.enable[c] && !state_reg.suspend_flag[c] &&
          (!top_priority_valid ||
           state_reg.ctrl[c][PRIO_LSB +: 2] > best)) begin
        top_priority_valid = 1'b1;
        top_priority_channel = CHAN_W'(c);
        best = state_reg.ctrl[c][PRIO_LSB +: 2];
      end
    end
  end

  // Output wiring
  always_comb begin
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      trigger_granularity[c*2 +: 2] = state_reg.ctrl[c][TRIG_GRAN_LSB +: 2];
    end
  end
  assign channel_trigger = state_reg.trig;
  assign channel_suspended = state_reg.suspend_flag;
  assign event_action_pulse = state_reg.act;
  assign event_out = state_reg.evo;
  assign irq = |(state_reg.flag & state_reg.mask);
  assign s_axi_awready = !state_reg.aw_held;
  assign s_axi_wready = !state_reg.w_held;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;

endmodule : dma_channel_trigger_event_control
`default_nettype wire

// [hdl/dma_trig_pkg.sv]
package dma_trig_pkg;
  // Channel geometry
  localparam int NUM_CHANNELS = 8;
  localparam int NUM_EVENT_CHANNELS = 4;
  localparam int CHAN_W = 3;
  // Register byte offsets
  localparam logic [7:0] CHANNEL_SELECT_OFFSET = 8'h3c;
  localparam logic [7:0] CHANNEL_ENABLE_OFFSET = 8'h40;
  localparam logic [7:0] CONTROL_OFFSET = 8'h44;
  localparam logic [7:0] SUSPEND_STATUS_OFFSET = 8'h48;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h50;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h54;
  // Control register field positions
  localparam int CMD_LSB = 24;
  localparam int TRIG_GRAN_LSB = 22;
  localparam int TRIG_SRC_LSB = 8;
  localparam int PRIO_LSB = 5;
  localparam int EVENT_OUTPUT_ENABLE_BIT = 4;
  localparam int EVENT_INPUT_ENABLE_BIT = 3;
  localparam int EVENT_INPUT_ACTION_LSB = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  // Command codes
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_SUSPEND = 2'h1;
  localparam logic [1:0] CMD_RESUME = 2'h2;
  // Trigger granularity codes
  localparam logic [1:0] GRAN_BLOCK = 2'h0;
  localparam logic [1:0] GRAN_RSVD = 2'h1;
  localparam logic [1:0] GRAN_BEAT = 2'h2;
  localparam logic [1:0] GRAN_TRANSACTION = 2'h3;
  // Trigger source map limits
  localparam logic [5:0] SRC_NONE = 6'h00;
  localparam logic [5:0] SRC_SERIAL_LAST = 6'h0a;
  localparam logic [5:0] SRC_TIMER_LAST = 6'h24;
  localparam logic [5:0] SRC_CONV_READY = 6'h25;
  localparam logic [5:0] SRC_DAC1_EMPTY = 6'h27;
  localparam logic [5:0] SRC_CIPHER_WR = 6'h2c;
  localparam logic [5:0] SRC_CIPHER_RD = 6'h2d;
  localparam int NUM_PERIPH_REQ = 46;
  // Event action codes
  localparam logic [2:0] EVENT_INPUT_ACTION_NONE = 3'h0;
  localparam logic [2:0] EVENT_INPUT_ACTION_TRANSFER = 3'h1;
  localparam logic [2:0] EVENT_INPUT_ACTION_COND_TRIGGER = 3'h2;
  localparam logic [2:0] EVENT_INPUT_ACTION_COND_BLOCK = 3'h3;
  localparam logic [2:0] EVENT_INPUT_ACTION_SUSPEND = 3'h4;
  localparam logic [2:0] EVENT_INPUT_ACTION_RESUME = 3'h5;
  localparam logic [2:0] EVENT_INPUT_ACTION_SKIP_SUSPEND = 3'h6;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dma_trig_pkg

// [bench/dma_trig_ctrl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module dma_trig_ctrl_asserts
  import dma_trig_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Requests and events
  input wire logic [NUM_PERIPH_REQ-1:0] periph_req,
  input wire logic [NUM_EVENT_CHANNELS-1:0] event_in,
  input wire logic [NUM_CHANNELS-1:0] event_out_cond,
  input wire logic [NUM_CHANNELS-1:0] channel_trigger,
  input wire logic [NUM_CHANNELS*3-1:0] event_action_pulse,
  input wire logic [NUM_EVENT_CHANNELS-1:0] event_out
);
  logic [6:0] req_hist;
  logic [6:0] ev_hist [NUM_EVENT_CHANNELS];
  // Short input history, since the synchronisers delay every cause
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_hist <= '0;
      for (int k = 0; k < NUM_EVENT_CHANNELS; k++) ev_hist[k] <= '0;
    end else begin
      req_hist <= {req_hist[5:0], |periph_req};
      for (int k = 0; k < NUM_EVENT_CHANNELS; k++) ev_hist[k] <= {ev_hist[k][5:0], event_in[k]};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_resp_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_bresp_hold: assert property (s_resp_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_excl: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read");
  a_trig_single: assert property ((channel_trigger & $past(channel_trigger)) == '0)
    else $error("trigger too long");
  a_trig_cause: assert property (|channel_trigger |-> |req_hist)
    else $error("trigger without request");
  a_evout_gate: assert property (
    (event_out & ~$past(event_out_cond[NUM_EVENT_CHANNELS-1:0])) == '0)
    else $error("event out without condition");
  // Action codes only where events are wired, and only legal ones
  for (genvar k = 0; k < NUM_CHANNELS; k++) begin : g_ch
    if (k < NUM_EVENT_CHANNELS) begin : g_ev
      a_event_input_action_legal: assert property (
        event_action_pulse[3*k+:3] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6})
        else $error("illegal action code");
      a_event_input_action_cause: assert property (
        event_action_pulse[3*k+:3] != 3'h0 |-> |ev_hist[k])
        else $error("action without event");
    end else begin : g_no
      a_event_input_action_absent: assert property (event_action_pulse[3*k+:3] == 3'h0)
        else $error("action on unwired channel");
    end
  end
endmodule : dma_trig_ctrl_asserts
`default_nettype wire

// [bench/req_event_model.sv]
`timescale 1ns/1ps
`default_nettype none
module req_event_model
  import dma_trig_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Request and event lines
  output logic [NUM_PERIPH_REQ-1:0] periph_req,
  output logic [NUM_EVENT_CHANNELS-1:0] event_in
);
  // Idle lines sit low
  initial begin
    periph_req = '0;
    event_in = '0;
  end
  // Line index is the source code; len gives a quick or slow requester
  task automatic pulse_req(input logic [5:0] code, input int len);
    @(posedge mclk);
    periph_req[code] <= 1'b1;
    repeat (len) @(posedge mclk);
    periph_req[code] <= 1'b0;
  endtask : pulse_req
  // One event on a channel line
  task automatic pulse_ev(input int k, input int len);
    @(posedge mclk);
    event_in[k] <= 1'b1;
    repeat (len) @(posedge mclk);
    event_in[k] <= 1'b0;
  endtask : pulse_ev
endmodule : req_event_model
`default_nettype wire

// [bench/dma_channel_trigger_event_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
module dma_channel_trigger_event_control_test;
  import dma_trig_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rng = 32'd76793;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, top_v;
  logic [1:0] bresp, rresp;
  logic [NUM_PERIPH_REQ-1:0] preq;
  logic [3:0] evin, evout, eo_acc;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] evcond = 8'h00, trig, suspend_flag, trig_acc;
  logic [15:0] gran;
  logic [23:0] event_input_action;
  logic [2:0] top_ch, act_acc;
  logic [31:0] ctl_m [NUM_CHANNELS];
  logic [5:0] codes [9] = '{6'h00, 6'h01, 6'h0a, 6'h0b, 6'h24, 6'h25, 6'h2c, 6'h2d, 6'h28};
  int n_mismatch = 0;
  int cmp_count = 0;
  // 25 MHz clock
  always #20 mclk = ~mclk;
  dma_channel_trigger_event_control dut_u (.mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periph_req(preq), .event_in(evin), .event_out_cond(evcond), .channel_trigger(trig),
    .trigger_granularity(gran), .channel_suspended(suspend_flag), .event_action_pulse(event_input_action),
    .event_out(evout), .top_priority_channel(top_ch), .top_priority_valid(top_v), .irq(irq));
  req_event_model pm_u (.mclk(mclk), .periph_req(preq), .event_in(evin));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Bus master: hold each channel until its ready is sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd
  task automatic ench(input int ch, input logic v);
    wr(CHANNEL_SELECT_OFFSET, 32'(ch), RESP_OKAY);
    wr(CHANNEL_ENABLE_OFFSET, {31'h0, v}, RESP_OKAY);
  endtask : ench
  // Model: enabled channels take only priority; event bits exist on low channels
  task automatic wctl(input int ch, input logic [31:0] d, input logic en);
    logic [31:0] m;
    m = en ? 32'h0000_0060 : (ch < NUM_EVENT_CHANNELS ? 32'h00c0_3f7f : 32'h00c0_3f60);
    wr(CHANNEL_SELECT_OFFSET, 32'(ch), RESP_OKAY);
    wr(CONTROL_OFFSET, d, RESP_OKAY);
    ctl_m[ch] = (ctl_m[ch] & ~m) | (d & m);
  endtask : wctl
  task automatic rctl(input int ch);
    wr(CHANNEL_SELECT_OFFSET, 32'(ch), RESP_OKAY);
    rd(CONTROL_OFFSET, ctl_m[ch], RESP_OKAY);
  endtask : rctl
  task automatic watch(input int n);
    trig_acc = '0;
    act_acc = '0;
    eo_acc = '0;
    repeat (n) begin
      @(posedge mclk);
      trig_acc |= trig;
      act_acc |= event_input_action[2:0];
      eo_acc |= evout;
    end
  endtask : watch
  task automatic trig_case(input logic [5:0] code, input logic [1:0] g);
    logic [7:0] e;
    e = (code == SRC_NONE || code inside {[6'h28:6'h2b]} || g == GRAN_RSVD) ? 8'h00 : 8'h02;
    ench(1, 1'b0);
    wctl(1, {8'h00, g, 8'h00, code, 8'h00}, 1'b0);
    ench(1, 1'b1);
    chk("granularity", {30'h0, g}, {30'h0, gran[3:2]});
    rng = xs(rng);
    fork
      pm_u.pulse_req(code, 2 + int'(rng[1:0]));
      watch(14);
    join
    chk("trigger", {24'h0, e}, {24'h0, trig_acc});
  endtask : trig_case
  // Hang guard, well beyond the expected run
  initial begin
    #1ms;
    n_mismatch++;
    complete_run();
  end
  initial begin
    for (int i = 0; i < NUM_CHANNELS; i++) ctl_m[i] = CONTROL_RESET;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int c = 0; c < NUM_CHANNELS; c++) rctl(c);
    rd(8'h7c, 32'h0, RESP_SLVERR);
    wr(8'h7c, 32'h1, RESP_SLVERR);
    // Random copies per channel, command field held at CMD_NONE
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      rng = xs(rng);
      wctl(c, rng & 32'hfcff_ffff, 1'b0);
    end
    for (int c = 0; c < NUM_CHANNELS; c++) rctl(c);
    ench(0, 1'b1);
    wctl(0, 32'h00ff_ffff, 1'b1);
    rctl(0);
    // Software suspend, flag, mask and clear
    wr(IRQ_MASK_OFFSET, 32'h0, RESP_OKAY);
    wctl(0, ctl_m[0] | 32'h0100_0000, 1'b1);
    chk("suspended", 32'h1, {24'h0, suspend_flag});
    rd(IRQ_STATUS_OFFSET, 32'h1, RESP_OKAY);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(IRQ_MASK_OFFSET, 32'h1, RESP_OKAY);
    chk("irq", 32'h1, {31'h0, irq});
    wr(IRQ_STATUS_OFFSET, 32'h1, RESP_OKAY);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wctl(0, ctl_m[0] | 32'h0200_0000, 1'b1);
    chk("resumed", 32'h0, {24'h0, suspend_flag});
    ench(0, 1'b0);
    foreach (codes[i]) trig_case(codes[i], GRAN_BLOCK);
    for (int g = 0; g < 4; g++) trig_case(6'h01, 2'(g));
    // Every action code, then two with event input off
    for (int a = 0; a < 10; a++) begin
      ench(0, 1'b0);
      wctl(0, {27'h0, a[0], a < 8, 3'(a % 8)}, 1'b0);
      ench(0, 1'b1);
      fork
        pm_u.pulse_ev(0, 2);
        watch(14);
        begin
          @(posedge mclk);
          evcond <= 8'h01;
          @(posedge mclk);
          evcond <= 8'h00;
        end
      join
      chk("action", (a < 8 && ((a % 8) inside {1, 2, 3, 6})) ? 32'(a) : 32'h0,
          {29'h0, act_acc});
      chk("event out", {31'h0, a[0]}, {28'h0, eo_acc});
      chk("ev suspend", {31'h0, a == 4}, {31'h0, suspend_flag[0]});
      chk("ev irq", {31'h0, a == 4}, {31'h0, irq});
      if (a == 4) wr(IRQ_STATUS_OFFSET, 32'h1, RESP_OKAY);
    end
    // Lane 1 alone reaches only the source field of an idle channel
    wr(CHANNEL_SELECT_OFFSET, 32'h3, RESP_OKAY);
    wstrb <= 4'h2;
    wr(CONTROL_OFFSET, 32'hffff_ffff, RESP_OKAY);
    wstrb <= 4'hf;
    ctl_m[3] = ctl_m[3] | 32'h0000_3f00;
    rd(CONTROL_OFFSET, ctl_m[3], RESP_OKAY);
    ench(2, 1'b1);
    wctl(2, 32'h0000_0040, 1'b1);
    chk("top channel", 32'h0000_000a, {28'h0, top_v, top_ch});
    complete_run();
  end
endmodule : dma_channel_trigger_event_control_test
bind dma_channel_trigger_event_control dma_trig_ctrl_asserts chk_u (.mclk(mclk), .rst_n(rst_n),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .periph_req(periph_req), .event_in(event_in),
  .event_out_cond(event_out_cond), .channel_trigger(channel_trigger),
  .event_action_pulse(event_action_pulse), .event_out(event_out));
`default_nettype wire
